// file: tmz_defs.vh
// constants for the timer-zero block with its shared prescaler
`ifndef TMZ_DEFS_VH
`define TMZ_DEFS_VH

// ==========================================================
// register offsets
`define TMZ_ADDR_COUNT      8'h01
`define TMZ_ADDR_OPTION     8'h81
`define TMZ_ADDR_INTCTL     8'h8b
`define TMZ_ADDR_EVSTAT     8'h9e
`define TMZ_ADDR_EVMASK     8'h9f

// ==========================================================
// reset values
`define TMZ_RST_COUNT       8'h00
`define TMZ_RST_OPTION      8'hff
`define TMZ_RST_INTCTL      8'h00
`define TMZ_RST_EVSTAT      2'h0
`define TMZ_RST_EVMASK      2'h0

// ==========================================================
// field positions, timer_option_control
`define TMZ_OPT_CS          5
`define TMZ_OPT_EDGE        4
`define TMZ_OPT_PSA         3
`define TMZ_OPT_RATE_HI     2
`define TMZ_OPT_RATE_LO     0

// field positions, interrupt_control
`define TMZ_INT_OVF_EN      5
`define TMZ_INT_OVF_FLAG    2

// field positions, event status and mask
`define TMZ_EV_OVF          0
`define TMZ_EV_WDT          1

// ==========================================================
// timing
`define TMZ_CLK_NS          100
`define TMZ_PIN_MARGIN_NS   20
`define TMZ_WR_INHIBIT      2'h2
`define TMZ_PHASE_Q2        2'h1
`define TMZ_PHASE_Q4        2'h3
`define TMZ_COUNT_MAX       8'hff

`endif

// file: tmz_timer0.v
// timer zero: 8-bit timer/counter with prescaler shared with watchdog
//
// How it works
// - clock source select clear: count increments each instruction cycle while the assign bit gives the prescaler to the watchdog
// - a count write stalls incrementing for the next two instruction cycles
// - clock source select set: count follows edges of the external pin
// - edge select clear counts rising edges, set counts falling edges
// - count wrapping from ff to 00 sets the overflow flag
// - overflow request passes only while overflow enable bit is set
// - overflow flag stays set until software clears it
// - timer halts during sleep, so overflow cannot wake the core
// - external count, after prescaler, is sampled on phase two and four
// - one 8-bit prescaler serves timer or watchdog, assign bit chooses
// - three-bit rate field selects the prescale ratio
// - prescaler counter has no read or write path
// - count write clears prescaler while it belongs to the timer
// - watchdog clear clears watchdog and prescaler when watchdog owns it
//
// Decided for this implementation: strobed register access.
`include "tmz_defs.vh"

module tmz_timer0
#(
  parameter WDT_W = 8
)
(
  input  wire       i_mclk,
  input  wire       i_rst_n,
  input  wire       i_ce,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output wire [7:0] o_rdata,
  input  wire       i_count_pin,
  input  wire       i_sleep,
  input  wire       i_wdt_base,
  input  wire       i_wdt_clear,
  output wire       o_wdt_timeout,
  output wire       o_irq
);

  // ==========================================================
  // state
  reg  [1:0]       phase_q;
  reg              pin_s1_q;
  reg              pin_s2_q;
  reg              pin_s3_q;
  reg  [7:0]       pre_q;
  reg  [7:0]       cnt_q;
  reg  [1:0]       inh_q;
  reg              pend_q;
  reg  [WDT_W-1:0] wdt_q;
  reg  [7:0]       opt_q;
  reg  [7:0]       intc_q;
  reg  [1:0]       evst_q;
  reg  [1:0]       evmk_q;
  reg  [7:0]       rdata_q;
  reg              irq_q;
  reg              wdto_q;

  // ==========================================================
  // decode
  wire       wr_cnt  = i_wr & (i_addr == `TMZ_ADDR_COUNT);
  wire       wr_opt  = i_wr & (i_addr == `TMZ_ADDR_OPTION);
  wire       wr_intc = i_wr & (i_addr == `TMZ_ADDR_INTCTL);
  wire       wr_evst = i_wr & (i_addr == `TMZ_ADDR_EVSTAT);
  wire       wr_evmk = i_wr & (i_addr == `TMZ_ADDR_EVMASK);

  wire       cs      = opt_q[`TMZ_OPT_CS];
  wire       edge_f  = opt_q[`TMZ_OPT_EDGE];
  wire       prescaler_assign     = opt_q[`TMZ_OPT_PSA];
  wire [2:0] rate    = opt_q[`TMZ_OPT_RATE_HI:`TMZ_OPT_RATE_LO];

  wire       awake   = ~i_sleep;
  wire       q2      = (phase_q == `TMZ_PHASE_Q2);
  wire       q4      = (phase_q == `TMZ_PHASE_Q4);

  // ==========================================================
  // external pin edge, read only after the second flop
  wire pin_rise = pin_s2_q & ~pin_s3_q;
  wire pin_fall = ~pin_s2_q & pin_s3_q;
  wire pin_evt  = edge_f ? pin_fall : pin_rise;

  // timer source: instruction cycle or pin edge, frozen asleep
  wire tmr_src  = awake & (cs ? pin_evt : q4);

  // ==========================================================
  // prescaler: per-bit masks for the two ratio tables
  wire [7:0] mask_t;
  wire [7:0] mask_w;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_mask
      assign mask_t[g] = (rate >= g);
      assign mask_w[g] = (rate > g);
    end
  endgenerate

  wire [7:0] mask    = prescaler_assign ? mask_w : mask_t;
  wire       pre_in  = prescaler_assign ? i_wdt_base : tmr_src;
  wire       pre_out = pre_in & (&(pre_q | ~mask));
  wire       pre_clr = (wr_cnt & ~prescaler_assign)
                     | (i_wdt_clear & prescaler_assign);

  // ==========================================================
  // counting path
  wire tmr_in  = prescaler_assign ? tmr_src : pre_out;
  // counter mode result is only taken at phase two and four
  wire samp    = awake & pend_q & (q2 | q4);
  wire inc     = cs ? samp : tmr_in;
  wire do_inc  = inc & (inh_q == 2'h0) & ~wr_cnt;
  wire ovf     = do_inc & (cnt_q == `TMZ_COUNT_MAX);

  wire wdt_in  = prescaler_assign ? pre_out : i_wdt_base;
  wire wdt_end = wdt_in & (&wdt_q);

  // ==========================================================
  // phase clock and pin synchroniser
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      phase_q  <= 2'h0;
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end
    else if (i_ce)
    begin
      phase_q  <= phase_q + 2'h1;
      pin_s1_q <= i_count_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // ==========================================================
  // prescaler, invisible to the register port
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pre_q <= 8'h00;
    end
    else if (i_ce)
    begin
      if (pre_clr)
      begin
        pre_q <= 8'h00;
      end
      else if (pre_in)
      begin
        pre_q <= pre_q + 8'h01;
      end
    end
  end

  // ==========================================================
  // count register, pending sample, write inhibit
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_q  <= `TMZ_RST_COUNT;
      inh_q  <= 2'h0;
      pend_q <= 1'b0;
    end
    else if (i_ce)
    begin
      if (wr_cnt)
      begin
        cnt_q <= i_wdata;
      end
      else if (do_inc)
      begin
        cnt_q <= cnt_q + 8'h01;
      end
      // a write always restarts the two-cycle stall
      if (wr_cnt)
      begin
        inh_q <= `TMZ_WR_INHIBIT;
      end
      else if (q4 && inh_q != 2'h0)
      begin
        inh_q <= inh_q - 2'h1;
      end
      // a fresh event in the sampling cycle keeps the latch set
      if (cs & tmr_in)
      begin
        pend_q <= 1'b1;
      end
      else if (samp | ~cs)
      begin
        pend_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // watchdog counter
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wdt_q  <= {WDT_W{1'b0}};
      wdto_q <= 1'b0;
    end
    else if (i_ce)
    begin
      wdto_q <= wdt_end & ~i_wdt_clear;
      if (i_wdt_clear)
      begin
        wdt_q <= {WDT_W{1'b0}};
      end
      else if (wdt_in)
      begin
        wdt_q <= wdt_q + {{(WDT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ==========================================================
  // control and interrupt registers
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      opt_q  <= `TMZ_RST_OPTION;
      intc_q <= `TMZ_RST_INTCTL;
      evst_q <= `TMZ_RST_EVSTAT;
      evmk_q <= `TMZ_RST_EVMASK;
      irq_q  <= 1'b0;
    end
    else if (i_ce)
    begin
      if (wr_opt)
      begin
        opt_q <= i_wdata;
      end
      if (wr_intc)
      begin
        intc_q <= i_wdata;
      end
      // hardware set wins over a software clear
      if (ovf)
      begin
        intc_q[`TMZ_INT_OVF_FLAG] <= 1'b1;
      end
      if (wr_evmk)
      begin
        evmk_q <= i_wdata[1:0];
      end
      evst_q[`TMZ_EV_OVF] <= ovf
        | (evst_q[`TMZ_EV_OVF] & ~(wr_evst & i_wdata[`TMZ_EV_OVF]));
      evst_q[`TMZ_EV_WDT] <= (wdt_end & ~i_wdt_clear)
        | (evst_q[`TMZ_EV_WDT] & ~(wr_evst & i_wdata[`TMZ_EV_WDT]));
      irq_q <= (evst_q[`TMZ_EV_OVF] & evmk_q[`TMZ_EV_OVF]
                & intc_q[`TMZ_INT_OVF_EN])
             | (evst_q[`TMZ_EV_WDT] & evmk_q[`TMZ_EV_WDT]);
    end
  end

  // ==========================================================
  // read port, data one cycle after the strobe
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_q <= 8'h00;
    end
    else if (i_ce)
    begin
      if (i_rd)
      begin
        case (i_addr)
          `TMZ_ADDR_COUNT:  rdata_q <= cnt_q;
          `TMZ_ADDR_OPTION: rdata_q <= opt_q;
          `TMZ_ADDR_INTCTL: rdata_q <= intc_q;
          `TMZ_ADDR_EVSTAT: rdata_q <= {6'h00, evst_q};
          `TMZ_ADDR_EVMASK: rdata_q <= {6'h00, evmk_q};
          default:          rdata_q <= 8'h00;
        endcase
      end
      else
      begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign o_rdata       = rdata_q;
  assign o_irq         = irq_q;
  assign o_wdt_timeout = wdto_q;

endmodule // tmz_timer0

// file: tmz_pulse_src.sv
// pulse source standing in for the outside count signal
module tmz_pulse_src
(
  input  wire logic       i_mclk,
  input  wire logic       i_idle,
  input  wire logic       i_go,
  input  wire logic [3:0] i_n,
  output wire logic       o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] left_q = 5'h00;
  logic [1:0] ph_q = 2'h0;
  // three clocks a half: both levels outlast two clocks plus margin
  assign o_pin = i_idle ^ (left_q != 5'h00 && !left_q[0]);
  always @(posedge i_mclk)
    if (i_go)
    begin
      left_q <= {i_n, 1'b0};
      ph_q   <= 2'h0;
    end
    else if (left_q != 5'h00)
    begin
      ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
      if (ph_q == 2'h2) left_q <= left_q - 5'h01;
    end
endmodule // tmz_pulse_src

// file: tmz_timer0_asserts.sv
// port checker for the timer-zero block
module tmz_timer0_asserts #(parameter WDT_W = 8)
(
  input wire logic i_mclk, i_rst_n, i_ce,
  input wire logic [7:0] i_addr, i_wdata,
  input wire logic i_wr, i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_count_pin, i_sleep, i_wdt_base, i_wdt_clear,
  input wire logic o_wdt_timeout, o_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] msk_q;
  logic       ien_q;
  logic       quiet;
  // no enabled source: overflow needs both mask and enable bit
  assign quiet = !msk_q[1] && !(msk_q[0] && ien_q);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  always_ff @(posedge i_mclk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      msk_q <= 2'h0;
      ien_q <= 1'b0;
    end
    else if (i_ce && i_wr)
    begin
      if (i_addr == 8'h9f) msk_q <= i_wdata[1:0];
      if (i_addr == 8'h8b) ien_q <= i_wdata[5];
    end
  // ==========
  // assertions
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("rdata outside read slot");
  rd_unmap_a: assert property ($past(i_rd) && !($past(i_addr) inside
    {8'h01, 8'h81, 8'h8b, 8'h9e, 8'h9f}) |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  irq_src_a: assert property ($rose(o_irq) |-> $past(!quiet))
    else $error("irq without enabled source");
  irq_quiet_a: assert property (quiet && $past(quiet) |-> !o_irq)
    else $error("masked irq passed");
  irq_fall_a: assert property ($fell(o_irq) |-> $past(i_wr, 2))
    else $error("irq dropped without write");
  wdt_gap_a: assert property (o_wdt_timeout |=> !o_wdt_timeout[*7])
    else $error("timeouts too close");
  wdt_cause_a: assert property (o_wdt_timeout |-> $past(i_wdt_base) ||
    $past(i_wdt_base, 2) || $past(i_wdt_base, 3))
    else $error("timeout without base tick");
  wdt_clr_a: assert property (i_wdt_clear |-> ##2 !o_wdt_timeout[*4])
    else $error("timeout after clear");
  cover property ($rose(o_irq));
  cover property (o_wdt_timeout);
  cover property (i_rd && i_addr == 8'h01 ##1 o_rdata != 8'h00);
endmodule // tmz_timer0_asserts

bind tmz_timer0 tmz_timer0_asserts #(.WDT_W(WDT_W)) u_chk
(
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_count_pin(i_count_pin), .i_sleep(i_sleep), .i_wdt_base(i_wdt_base),
  .i_wdt_clear(i_wdt_clear), .o_wdt_timeout(o_wdt_timeout), .o_irq(o_irq)
);

// file: tmz_timer0_tb.sv
// self-checking bench for the timer-zero block
module tmz_timer0_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst_n = 0, wr = 0, rd = 0, sleep = 0;
  logic wbase = 0, wclr = 0, idle = 0, go = 0, pin, wto, irq;
  logic [7:0] addr = 0, wdata = 0, rdata, rv, v, t;
  logic [3:0] n = 0;
  int error_cnt = 0, comparisons = 0, seed = 27;
  initial forever #50 mclk = ~mclk;
  tmz_timer0 #(.WDT_W(3)) i_dut
  (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_ce(1'b1), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_count_pin(pin), .i_sleep(sleep), .i_wdt_base(wbase),
    .i_wdt_clear(wclr), .o_wdt_timeout(wto), .o_irq(irq)
  );
  tmz_pulse_src i_src
    (.i_mclk(mclk), .i_idle(idle), .i_go(go), .i_n(n), .o_pin(pin));
  // ==========
  // bus tasks and expectations
  function automatic int per(input int r); // clocks per count
    return 8 << r;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wrr(input logic [7:0] a, d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask
  task automatic chk(input logic [7:0] g, e);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic pulses;
    @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    cyc(6 * n + 12);
    rdr(8'h01);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========
  // main sequence
  initial
  begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rdr(8'h81);
    chk(rv, 8'hff);
    rdr(8'h02);
    chk(rv, 8'h00);
    wrr(8'h81, 8'h08);
    rdr(8'h01);
    v = rv;
    cyc(38);
    rdr(8'h01);
    chk(rv, v + 8'h0a);
    t = 8'($random(seed));
    wrr(8'h01, t);
    cyc(38);
    rdr(8'h01);
    v = rv - t;
    chk(8'(v == 8'h07 || v == 8'h08), 8'h01);
    for (int r = 0; r < 8; r++)
    begin
      wrr(8'h81, 8'(r));
      rdr(8'h01);
      v = rv;
      cyc(3 * per(r) - 2);
      rdr(8'h01);
      chk(rv, v + 8'h03);
    end
    // a count write must restart the 1:256 prescaler from zero
    t = 8'($random(seed));
    wrr(8'h01, t);
    cyc(1000);
    rdr(8'h01);
    chk(rv, t);
    cyc(30);
    rdr(8'h01);
    chk(rv, t + 8'h01);
    wrr(8'h81, 8'h28);
    n = 4'($random(seed)) | 4'h1;
    rdr(8'h01);
    v = rv;
    pulses;
    chk(rv, v + 8'(n));
    wrr(8'h81, 8'h38);
    rdr(8'h01);
    v = rv;
    idle <= 1'b1;
    pulses;
    chk(rv, v + 8'(n));
    idle <= 1'b0;
    cyc(12);
    rdr(8'h01);
    chk(rv, v + 8'(n) + 8'h01);
    wrr(8'h81, 8'h08);
    sleep <= 1'b1;
    rdr(8'h01);
    v = rv;
    cyc(38);
    rdr(8'h01);
    chk(rv, v);
    sleep <= 1'b0;
    wrr(8'h9f, 8'h01);
    wrr(8'h8b, 8'h20);
    wrr(8'h01, 8'hfe);
    for (int k = 0; k < 40 && irq !== 1'b1; k++) cyc(1);
    chk(8'(irq), 8'h01);
    if (irq !== 1'b1) tally_and_finish;
    rdr(8'h8b);
    chk(rv, 8'h24);
    rdr(8'h9e);
    chk(rv, 8'h01);
    cyc(40);
    chk(8'(irq), 8'h01);
    wrr(8'h8b, 8'h04);
    cyc(2);
    chk(8'(irq), 8'h00);
    wrr(8'h9e, 8'h01);
    wrr(8'h8b, 8'h20);
    cyc(2);
    chk(8'(irq), 8'h00);
    wrr(8'h9f, 8'h02);
    wbase <= 1'b1;
    repeat (10)
    begin
      repeat (3) @(posedge mclk);
      wclr <= 1'b1;
      @(posedge mclk);
      wclr <= 1'b0;
    end
    rdr(8'h9e);
    chk(rv, 8'h00);
    cyc(12);
    rdr(8'h9e);
    chk(rv, 8'h02);
    chk(8'(irq), 8'h01);
    // the timeout pulse stands one cycle, so poll every cycle
    for (int k = 0; k < 12 && wto !== 1'b1; k++) cyc(1);
    chk(8'(wto), 8'h01);
    tally_and_finish;
  end
endmodule // tmz_timer0_tb
